// File: logic/nsl_pkg.sv
// Package for the network status LED blinker: constants, types, register map
package nsl_pkg;

	// Clock and timebase
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_NS       = 1_000_000;
	localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;

	// Pattern durations in milliseconds
	localparam logic [11:0] PRE_ON_MS    = 12'd100;
	localparam logic [11:0] PRE_OFF_MS   = 12'd900;
	localparam logic [11:0] SLOW_ON_MS   = 12'd200;
	localparam logic [11:0] SLOW_OFF_MS  = 12'd2000;
	localparam logic [11:0] QUICK_ON_MS  = 12'd200;
	localparam logic [11:0] QUICK_OFF_MS = 12'd600;
	localparam logic [11:0] VQ_ON_MS     = 12'd100;
	localparam logic [11:0] VQ_OFF_MS    = 12'd200;
	localparam logic [11:0] INIT_MS      = 12'd2000;

	// Register map (byte addresses)
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;

	// Control field positions
	localparam int CTRL_ON_BIT   = 0;
	localparam int CTRL_WIN_BIT  = 1;
	localparam int CTRL_CHG_BIT  = 2;
	localparam int CTRL_REG_BIT  = 3;
	localparam int CTRL_CALL_BIT = 4;
	localparam int CTRL_BAD_BIT  = 5;
	localparam logic [5:0] CTRL_RST = 6'h00;

	typedef enum logic [2:0] {
		PAT_DARK,
		PAT_PRECHG,
		PAT_STEADY,
		PAT_SLOW,
		PAT_QUICK,
		PAT_VQUICK
	} nsl_pat_t;

	typedef struct packed {
		logic bad_image;
		logic call_active;
		logic registered;
		logic charger_input;
		logic battery_supply_in_window;
		logic module_on;
	} nsl_ctrl_t;

	typedef struct packed {
		logic [11:0] on_ms;
		logic [11:0] off_ms;
		logic        steady;
		logic        blink;
	} nsl_timing_t;

endpackage

// File: logic/nsl_blinker.sv
// Network status LED pattern generator with an Avalon-MM register slave
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none

// Operation
// R1: Indicator pin only pulls low (LED on) or releases (LED off).
// R2: Module off, battery in window, charger present: 100 ms on, 900 ms off.
// R3: Module on: pattern follows registration and software health, not charging.
// R4: On but unregistered: LED lit steadily.
// R5: Registered and idle: 200 ms on, 2 s off.
// R6: Registered with communication: 200 ms on, 600 ms off.
// R7: Bad software image: 100 ms on, 200 ms off.
// R8: During reset the pin is released so the LED is dark.
// R9: Up to 2 s after reset the pin is meaningless; then true status.
// R10: Durations timed from a millisecond tick; pattern restarts on status change.
// R11: Priority: bad software, then communication, then registered, then unregistered.
module nsl_blinker
	import nsl_pkg::*;
#(
	parameter int P_TICK_CYC = TICK_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	output logic             o_status_led_out,
	output logic             o_status_led_oe
);

	function automatic nsl_timing_t pat_timing(input nsl_pat_t p);
		nsl_timing_t t;
		t = '{on_ms: 12'h000, off_ms: 12'h000, steady: 1'b0, blink: 1'b0};
		case (p)
			PAT_PRECHG: t = '{on_ms: PRE_ON_MS, off_ms: PRE_OFF_MS, steady: 1'b0, blink: 1'b1};
			PAT_STEADY: t = '{on_ms: 12'h000, off_ms: 12'h000, steady: 1'b1, blink: 1'b0};
			PAT_SLOW:   t = '{on_ms: SLOW_ON_MS, off_ms: SLOW_OFF_MS, steady: 1'b0, blink: 1'b1};
			PAT_QUICK:  t = '{on_ms: QUICK_ON_MS, off_ms: QUICK_OFF_MS, steady: 1'b0, blink: 1'b1};
			PAT_VQUICK: t = '{on_ms: VQ_ON_MS, off_ms: VQ_OFF_MS, steady: 1'b0, blink: 1'b1};
			default:    t = '{on_ms: 12'h000, off_ms: 12'h000, steady: 1'b0, blink: 1'b0};
		endcase
		return t;
	endfunction

	// End of a phase: the count has reached its last millisecond
	function automatic logic ms_last(input logic [11:0] cnt, input logic [11:0] len);
		return cnt == len - 12'h001;
	endfunction

	nsl_ctrl_t   ctrl_q,      ctrl_d;
	logic        wait_q,      wait_d;
	logic [31:0] rdata_q,     rdata_d;
	logic [31:0] tick_cnt_q,  tick_cnt_d;
	logic        tick_q,      tick_d;
	logic [11:0] ms_cnt_q,    ms_cnt_d;
	logic        on_phase_q,  on_phase_d;
	nsl_pat_t    pat_q,       pat_d;
	logic [11:0] init_cnt_q,  init_cnt_d;
	logic        init_done_q, init_done_d;
	logic        led_on_q,    led_on_d;

	nsl_pat_t    pat_sel;
	nsl_timing_t tim;
	logic        req;
	logic        acc;

	always_comb begin
		// Module off: only the pre-charge flash can show
		if (!ctrl_q.module_on) begin
			if (ctrl_q.battery_supply_in_window && ctrl_q.charger_input) begin
				pat_sel = PAT_PRECHG; // R2
			end else begin
				pat_sel = PAT_DARK; // R2
			end
		end else if (ctrl_q.bad_image) begin
			pat_sel = PAT_VQUICK; // R3 R7 R11
		end else if (ctrl_q.registered && ctrl_q.call_active) begin
			pat_sel = PAT_QUICK; // R6 R11
		end else if (ctrl_q.registered) begin
			pat_sel = PAT_SLOW; // R5 R11
		end else begin
			pat_sel = PAT_STEADY; // R4 R11
		end
	end

	// Bus group: one wait state on every access
	always_comb begin
		req = i_avs_read | i_avs_write;
		// Access completes on the edge where waitrequest is seen low
		acc = req & ~wait_q;
		// Idle high, so read data always has a cycle to settle
		wait_d = ~(req & wait_q);
		ctrl_d = ctrl_q;
		if (acc && i_avs_write && i_avs_address == CTRL_OFS && i_avs_byteenable[0]) begin
			ctrl_d = nsl_ctrl_t'(i_avs_writedata[5:0]);
		end
		rdata_d = rdata_q;
		if (req && wait_q) begin
			if (i_avs_address == CTRL_OFS) begin
				rdata_d = {26'h0000000, ctrl_q};
			end else if (i_avs_address == STAT_OFS) begin
				rdata_d = {12'h000, ms_cnt_q, 2'h0, init_done_q, led_on_q, on_phase_q, pat_q};
			end else begin
				rdata_d = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q  <= nsl_ctrl_t'(CTRL_RST);
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			ctrl_q  <= ctrl_d;
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// Timebase group
	always_comb begin
		// Millisecond tick from the system clock
		if (tick_cnt_q == 32'(P_TICK_CYC - 1)) begin
			tick_cnt_d = 32'h0000_0000; // R10
			tick_d     = 1'b1;
		end else begin
			tick_cnt_d = tick_cnt_q + 32'h0000_0001;
			tick_d     = 1'b0;
		end

		// Start-up interval counts once and then holds
		init_cnt_d  = init_cnt_q;
		init_done_d = init_done_q;
		if (!init_done_q && tick_q) begin
			if (ms_last(init_cnt_q, INIT_MS)) begin
				init_done_d = 1'b1; // R9
			end else begin
				init_cnt_d = init_cnt_q + 12'h001;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tick_cnt_q  <= 32'h0000_0000;
			tick_q      <= 1'b0;
			init_cnt_q  <= 12'h000;
			init_done_q <= 1'b0;
		end else begin
			tick_cnt_q  <= tick_cnt_d;
			tick_q      <= tick_d;
			init_cnt_q  <= init_cnt_d;
			init_done_q <= init_done_d;
		end
	end

	// Pattern group
	always_comb begin
		tim        = pat_timing(pat_q);
		pat_d      = pat_sel;
		ms_cnt_d   = ms_cnt_q;
		on_phase_d = on_phase_q;
		if (pat_sel != pat_q) begin
			// Restart at the on phase so a status change shows at once
			ms_cnt_d   = 12'h000; // R10
			on_phase_d = 1'b1;
		end else if (tim.blink && tick_q) begin
			// Tick runs free, so the first on phase may be up to 1 ms short
			if (on_phase_q && ms_last(ms_cnt_q, tim.on_ms)) begin
				ms_cnt_d   = 12'h000;
				on_phase_d = 1'b0;
			end else if (!on_phase_q && ms_last(ms_cnt_q, tim.off_ms)) begin
				ms_cnt_d   = 12'h000;
				on_phase_d = 1'b1;
			end else begin
				ms_cnt_d = ms_cnt_q + 12'h001;
			end
		end

		// Kept dark through start-up rather than toggling
		led_on_d = init_done_q & (tim.steady | (tim.blink & on_phase_q)); // R9
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ms_cnt_q   <= 12'h000;
			on_phase_q <= 1'b1;
			pat_q      <= PAT_DARK;
			led_on_q   <= 1'b0; // R8
		end else begin
			ms_cnt_q   <= ms_cnt_d;
			on_phase_q <= on_phase_d;
			pat_q      <= pat_d;
			led_on_q   <= led_on_d;
		end
	end

	// Open drain: data is always low, only the enable moves
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_status_led_out  <= 1'b0; // R1
			o_status_led_oe   <= 1'b0; // R8
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h0000_0000;
		end else begin
			o_status_led_out  <= 1'b0; // R1
			o_status_led_oe   <= led_on_d; // R1
			o_avs_waitrequest <= wait_d;
			o_avs_readdata    <= rdata_d;
		end
	end

endmodule

`default_nettype wire

// File: testbench/nsl_led_model.sv
// External LED and series resistor to the battery supply
`timescale 1ns/1ns
`default_nettype none
module nsl_led_model (
	input  wire logic i_out,
	input  wire logic i_oe,
	output logic      o_pin,
	output logic      o_lit
);
	// Released pin is pulled up to the battery through the LED
	assign o_pin = i_oe ? i_out : 1'b1;
	assign o_lit = !o_pin;
endmodule
`default_nettype wire

// File: testbench/nsl_blinker_asserts.sv
// Port assertions for the LED blinker
`timescale 1ns/1ns
`default_nettype none
module nsl_blinker_asserts #(
	parameter int P_TICK_CYC = 2
) (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic [3:0]  i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0]  i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	input wire logic        o_status_led_out,
	input wire logic        o_status_led_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	int up_q;
	int up_d;
	logic tk;
	// Saturates so it cannot wrap in long runs
	always_comb up_d = (up_q < 2010 * P_TICK_CYC) ? up_q + 1 : up_q;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			up_q <= 0;
		else
			up_q <= up_d;
	end
	assign tk = i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0 && i_avs_byteenable[0];
	a_led_drain_only: assert property (o_status_led_out == 1'b0) else $error("pin driven high");
	a_reset_led_dark: assert property (disable iff (1'b0) i_rst |-> !o_status_led_oe)
		else $error("LED on in reset");
	a_init_led_dark: assert property (up_q < 1999 * P_TICK_CYC |-> !o_status_led_oe)
		else $error("LED on in start-up");
	a_change_on_phase: assert property (tk && i_avs_writedata[0] && up_q == 2010 * P_TICK_CYC |-> ##3 o_status_led_oe)
		else $error("no on phase after change");
	a_wait_one_low: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("waitrequest low twice");
	a_req_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("no answer");
	a_idle_wait: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest) else $error("answer unasked");
	a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address != 4'h0
		&& i_avs_address != 4'h4 |-> o_avs_readdata == 32'h0) else $error("unmapped read not zero");
	c_ctrl_write: cover property (tk);
	c_led_on: cover property ($rose(o_status_led_oe));
	c_led_off: cover property ($fell(o_status_led_oe));
endmodule
`default_nettype wire

// File: testbench/nsl_blinker_tb_top.sv
// Self-checking testbench for the LED blinker
`timescale 1ns/1ns
`default_nettype none
module nsl_blinker_tb_top;
	import nsl_pkg::*;
	localparam int P = 2;
	logic i_clk = 0, i_rst = 1, rd = 0, wr = 0, wq, lo, oe, pin, lit;
	logic [3:0] ad = 0, be = 4'hF;
	logic [31:0] wd = 0, rdat, q;
	int failures = 0, tests_run = 0, n;
	nsl_blinker #(.P_TICK_CYC(P)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(ad), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wq), .o_status_led_out(lo), .o_status_led_oe(oe));
	nsl_led_model led (.i_out(lo), .i_oe(oe), .o_pin(pin), .o_lit(lit));
	always #10 i_clk = !i_clk;
	task chk(input bit ok, input string m);
		tests_run++;
		if (!ok) begin
			failures++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		ad <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (wq !== 1'b0 && n < 50);
		q = rdat;
		wr <= 0;
		rd <= 0;
		chk(n < 50, "bus hang");
	endtask
	task run(input logic lv);
		n = 0;
		while (lit === lv && n < 5000) begin
			@(posedge i_clk);
			n++;
		end
	endtask
	task blink(input logic [5:0] c, input int on, input int off);
		bus(1, CTRL_OFS, {26'h0, c});
		repeat (3) @(posedge i_clk);
		chk(lit === 1'b1, "no restart");
		run(1);
		run(0);
		run(1);
		chk(n >= (on - 1) * P && n <= on * P, "on time");
		run(0);
		chk(n >= (off - 1) * P && n <= off * P, "off time");
	endtask
	task t_init;
		bus(1, CTRL_OFS, 32'h01);
		repeat (1990 * P) @(posedge i_clk) chk(lit === 1'b0, "lit in start-up");
		repeat (20 * P) @(posedge i_clk);
		run(1);
		chk(n == 5000, "steady not lit");
	endtask
	task t_bus;
		be <= 4'h0;
		bus(1, CTRL_OFS, 32'h02);
		be <= 4'hF;
		bus(1, 4'h8, 32'h02);
		bus(0, CTRL_OFS, 32'h0);
		chk(q === 32'h0000_0001, "control readback");
		bus(0, STAT_OFS, 32'h0);
		chk(q === {26'h0, 1'b1, 1'b1, 1'b1, PAT_STEADY}, "status readback");
		bus(0, 4'hC, 32'h0);
		chk(q === 32'h0, "unmapped read");
		repeat (3) @(posedge i_clk);
		chk(lit === 1'b1, "ignored write took effect");
	endtask
	task t_blink;
		blink(6'h06, PRE_ON_MS, PRE_OFF_MS);
		blink(6'h09, SLOW_ON_MS, SLOW_OFF_MS);
		blink(6'h39, VQ_ON_MS, VQ_OFF_MS);
		blink(6'h19, QUICK_ON_MS, QUICK_OFF_MS);
		blink(6'h0F, SLOW_ON_MS, SLOW_OFF_MS);
		blink(6'h21, VQ_ON_MS, VQ_OFF_MS);
	endtask
	task t_dark;
		bus(1, CTRL_OFS, 32'h02);
		repeat (3) @(posedge i_clk);
		run(0);
		chk(n == 5000, "lit without charger");
	endtask
	task t_reset;
		bus(1, CTRL_OFS, 32'h01);
		repeat (3) @(posedge i_clk);
		chk(lit === 1'b1, "steady not lit");
		i_rst <= 1;
		repeat (2) @(posedge i_clk);
		chk(lit === 1'b0 && wq === 1'b1, "not idle in reset");
		i_rst <= 0;
		bus(0, CTRL_OFS, 32'h0);
		chk(q === {26'h0, CTRL_RST}, "control not cleared");
		bus(1, CTRL_OFS, 32'h01);
		repeat (1900 * P) @(posedge i_clk) chk(lit === 1'b0, "lit in start-up");
	endtask
	task results;
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Whole run needs about 45k cycles
	initial begin
		repeat (70000) @(posedge i_clk);
		failures++;
		results;
	end
	initial begin
		repeat (6) @(posedge i_clk);
		chk(pin === 1'b1, "pin low in reset");
		i_rst <= 0;
		t_init;
		t_bus;
		t_blink;
		t_dark;
		t_reset;
		results;
	end
endmodule
bind nsl_blinker nsl_blinker_asserts #(.P_TICK_CYC(P_TICK_CYC)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .o_status_led_out(o_status_led_out), .o_status_led_oe(o_status_led_oe));
`default_nettype wire
